// ===== core/mosy_map.svh
// Constants for the memory ordering and fetch sync block.
// Assumes inclusion by bare name from core/ files.
`ifndef MOSY_MAP_SVH
`define MOSY_MAP_SVH
`define MOSY_ADDR_W      32
`define MOSY_DW_MASK     32'hFFFF_FFF8
`define MOSY_INSN_BYTES  32'h0000_0004
`define MOSY_CNT_W       8
`define MOSY_CNT_ZERO    8'h00
`define MOSY_CNT_ONE     8'h01
`endif

// ===== core/mosy_pkg.sv
// Types for the memory ordering and fetch sync block.
// Assumes mosy_map.svh for widths.
`include "mosy_map.svh"
package mosy_pkg;
   typedef enum logic [1:0] {
      MOSY_OP_NONE,
      MOSY_OP_IOB,
      MOSY_OP_FSYNC,
      MOSY_OP_ISYNC
   } mosy_op_t;

   typedef enum logic [1:0] {
      MOSY_BUS_NONE,
      MOSY_BUS_IOB,
      MOSY_BUS_FSYNC
   } mosy_bus_t;

   typedef enum {
      MOSY_IDLE,
      MOSY_DRAIN,
      MOSY_BUS,
      MOSY_WAIT_CMP,
      MOSY_FLUSH
   } mosy_st_t;

   typedef struct packed {
      logic                     valid;
      mosy_op_t                 op;
      logic [`MOSY_ADDR_W-1:0]  pc;
   } mosy_disp_t;

   typedef struct packed {
      logic                     valid;
      logic [`MOSY_ADDR_W-1:0]  addr;
   } mosy_fetch_t;
endpackage

// ===== core/mosy_ord_cnt.sv
// Counter of uncached or write-through accesses in flight.
// Assumes issue and done are single-cycle pulses.
`timescale 1ns/1ps
`include "mosy_map.svh"
module mosy_ord_cnt #(
   parameter int CNT_W = `MOSY_CNT_W
) (
   input  wire logic             clk_sys,
   input  wire logic             srst,
   input  wire logic             issue,
   input  wire logic             done,
   output logic                  empty
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } mosy_cnt_st_t;

   mosy_cnt_st_t st_r;
   mosy_cnt_st_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (issue && !done) begin
         st_nxt.cnt = st_r.cnt + CNT_W'(`MOSY_CNT_ONE);
      end else if (done && !issue) begin
         st_nxt.cnt = st_r.cnt - CNT_W'(`MOSY_CNT_ONE);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign empty = (st_r.cnt == CNT_W'(`MOSY_CNT_ZERO));
endmodule

// ===== core/mosy_ctrl.sv
// Barrier sequencer: I/O ordering barrier, full sync, fetch sync.
// Assumes dispatch, load/store and completion pulses on clk_sys.
`timescale 1ns/1ps
`include "mosy_map.svh"

// Behaviour
// [RL1] Every I/O ordering barrier goes to the load/store unit.
// [RL2] The barrier waits until older uncached accesses have executed.
// [RL3] Younger uncached accesses are held until the barrier executes.
// [RL4] The barrier puts an address-only ordering cycle on the bus.
// [RL5] A fetch sync first waits for all older instructions to complete.
// [RL6] It then purges prefetch buffers and refetches the next double word.
// [RL7] A second-level cache drains its queues before acking a sync cycle.
// [RL8] After a full sync dispatches nothing more dispatches till it ends.
// [RL9] The full sync runs in the load/store unit and goes on the bus.
// [RL10] The barrier completes only once the bus accepts its cycle.
module mosy_ctrl (
   input  wire logic                 clk_sys,
   input  wire logic                 srst,
   input  mosy_pkg::mosy_disp_t      disp_in,
   output logic                      disp_ready,
   output logic                      load_store_unit_op_valid,
   output mosy_pkg::mosy_op_t        load_store_unit_op,
   input  wire logic                 uc_issue_req,
   output logic                      uc_issue_ok,
   input  wire logic                 uc_done,
   input  wire logic                 older_all_done,
   output logic                      bus_req,
   output mosy_pkg::mosy_bus_t       bus_kind,
   input  wire logic                 bus_ack,
   output logic                      pf_flush,
   output mosy_pkg::mosy_fetch_t     refetch,
   output logic                      sync_done
);
   typedef struct packed {
      mosy_pkg::mosy_st_t     st;
      mosy_pkg::mosy_op_t     op;
      logic [`MOSY_ADDR_W-1:0] pc;
      logic                   unit_v;
      mosy_pkg::mosy_bus_t    bus;
      logic                   flush;
      mosy_pkg::mosy_fetch_t  fetch;
      logic                   done;
   } mosy_ctl_st_t;

   mosy_ctl_st_t st_r;
   mosy_ctl_st_t st_nxt;
   logic         uc_empty;
   logic         take;

   function automatic logic to_unit(input mosy_pkg::mosy_op_t op);
      to_unit = (op == mosy_pkg::MOSY_OP_IOB) ||
               (op == mosy_pkg::MOSY_OP_FSYNC);
   endfunction

   function automatic logic is_barrier(input mosy_pkg::mosy_op_t op);
      is_barrier = (op != mosy_pkg::MOSY_OP_NONE);
   endfunction

   // Counts uncached accesses issued but not yet executed
   mosy_ord_cnt #(
      .CNT_W (`MOSY_CNT_W)
   ) u_cnt (
      .clk_sys (clk_sys),
      .srst    (srst),
      .issue   (uc_issue_req && uc_issue_ok),
      .done    (uc_done),
      .empty   (uc_empty)
   );

   // [RL8] Dispatch stall during any barrier
   assign disp_ready = (st_r.st == mosy_pkg::MOSY_IDLE);
   assign take = disp_in.valid && disp_ready && is_barrier(disp_in.op);

   // [RL3] Hold younger uncached accesses
   assign uc_issue_ok = (st_r.st == mosy_pkg::MOSY_IDLE) && !take;

   always_comb begin
      st_nxt       = st_r;
      st_nxt.unit_v = 1'b0;
      st_nxt.flush = 1'b0;
      st_nxt.done  = 1'b0;
      st_nxt.fetch.valid = 1'b0;
      case (st_r.st)
         mosy_pkg::MOSY_IDLE: begin
            if (take) begin
               st_nxt.op = disp_in.op;
               st_nxt.pc = disp_in.pc;
               // [RL1] Route IOB and FSYNC barriers to load/store unit, not ISYNC
               st_nxt.unit_v = to_unit(disp_in.op);
               st_nxt.st = mosy_pkg::MOSY_DRAIN;
            end
         end
         mosy_pkg::MOSY_DRAIN: begin
            if (st_r.op == mosy_pkg::MOSY_OP_IOB) begin
               // [RL2] Wait for older uncached accesses
               if (uc_empty) begin
                  // [RL4] Address-only ordering cycle
                  st_nxt.bus = mosy_pkg::MOSY_BUS_IOB;
                  st_nxt.st  = mosy_pkg::MOSY_BUS;
               end
            end else if (older_all_done) begin
               // [RL5] Older instructions complete
               if (st_r.op == mosy_pkg::MOSY_OP_FSYNC) begin
                  // [RL9] Full sync broadcast
                  st_nxt.bus = mosy_pkg::MOSY_BUS_FSYNC;
                  st_nxt.st  = mosy_pkg::MOSY_BUS;
               end else begin
                  st_nxt.st = mosy_pkg::MOSY_FLUSH;
               end
            end
         end
         mosy_pkg::MOSY_BUS: begin
            // [RL10] Done only when bus accepts
            if (bus_ack) begin
               st_nxt.bus = mosy_pkg::MOSY_BUS_NONE;
               st_nxt.st  = mosy_pkg::MOSY_WAIT_CMP;
            end
         end
         mosy_pkg::MOSY_WAIT_CMP: begin
            st_nxt.done = 1'b1;
            st_nxt.st   = mosy_pkg::MOSY_IDLE;
         end
         mosy_pkg::MOSY_FLUSH: begin
            // [RL6] Purge and refetch next double word
            st_nxt.flush = 1'b1;
            st_nxt.fetch.valid = 1'b1;
            st_nxt.fetch.addr  = (st_r.pc + `MOSY_INSN_BYTES) &
                                 `MOSY_DW_MASK;
            st_nxt.done = 1'b1;
            st_nxt.st   = mosy_pkg::MOSY_IDLE;
         end
         default: st_nxt.st = mosy_pkg::MOSY_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_r <= '{st: mosy_pkg::MOSY_IDLE, op: mosy_pkg::MOSY_OP_NONE,
                   bus: mosy_pkg::MOSY_BUS_NONE, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign load_store_unit_op_valid = st_r.unit_v;
   assign load_store_unit_op       = st_r.op;
   assign bus_req      = (st_r.st == mosy_pkg::MOSY_BUS);
   assign bus_kind     = st_r.bus;
   assign pf_flush     = st_r.flush;
   assign refetch      = st_r.fetch;
   assign sync_done    = st_r.done;
endmodule

// ===== tb/mosy_ctrl_props.sv
// Port assertions for the barrier sequencer.
// Assumes a bind onto mosy_ctrl; one clock, sync reset.
`timescale 1ns/1ps
module mosy_ctrl_props (
   input logic                  clk_sys, srst, disp_ready,
   input logic                  load_store_unit_op_valid,
   input logic                  uc_issue_ok, older_all_done, bus_req,
   input logic                  bus_ack, pf_flush, sync_done,
   input mosy_pkg::mosy_disp_t  disp_in,
   input mosy_pkg::mosy_op_t    load_store_unit_op,
   input mosy_pkg::mosy_bus_t   bus_kind,
   input mosy_pkg::mosy_fetch_t refetch
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence end_s;
      !bus_req ##1 sync_done;
   endsequence
   // Odd parity of op picks IOB or FSYNC
   route_a: assert property (
      disp_in.valid && disp_ready && ^disp_in.op |=>
      load_store_unit_op_valid && load_store_unit_op == $past(disp_in.op))
      else $error("route");
   late_hold_a: assert property (
      !disp_ready |-> !uc_issue_ok) else $error("hold");
   bus_hold_a: assert property (
      bus_req && !bus_ack |=> bus_req && $stable(bus_kind))
      else $error("bus");
   ack_done_a: assert property (
      bus_req && bus_ack |=> end_s) else $error("ack");
   fsync_wait_a: assert property (
      $rose(bus_req) && bus_kind == mosy_pkg::MOSY_BUS_FSYNC |->
      $past(older_all_done)) else $error("fsync");
   isync_wait_a: assert property (
      pf_flush |-> $past(older_all_done, 2)) else $error("isync");
   refetch_a: assert property (
      pf_flush |-> refetch.valid && sync_done && refetch.addr[2:0] == 3'h0)
      else $error("refetch");
   done_ready_a: assert property (
      sync_done |=> disp_ready) else $error("ready");
endmodule

bind mosy_ctrl mosy_ctrl_props chk (.*);

// ===== tb/mosy_bus_model.sv
// Bus responder: acks each address-only cycle lat+1 cycles after bus_req rises.
// Assumes bus_req holds until the ack edge.
`timescale 1ns/1ps
module mosy_bus_model (
   input  logic       clk_sys, srst, bus_req,
   input  logic [3:0] lat,
   output logic       bus_ack
);
   logic [3:0] wait_r;
   always @(posedge clk_sys) begin
      bus_ack <= !srst && bus_req && !bus_ack && wait_r == lat;
      wait_r <= (srst || !bus_req || bus_ack) ? 4'h0 : wait_r + 4'h1;
   end
endmodule

// ===== tb/test_mosy_ctrl.sv
// Barrier sequencer bench: table rows, then awkward cases.
// Assumes core files, bus model and checker compiled first.
`timescale 1ns/1ps
module test_mosy_ctrl;
   typedef struct {mosy_pkg::mosy_op_t op; logic [31:0] pc;} mosy_row_t;
   mosy_row_t rows [3] = '{'{mosy_pkg::MOSY_OP_IOB, 32'h100},
      '{mosy_pkg::MOSY_OP_FSYNC, 32'h104}, '{mosy_pkg::MOSY_OP_ISYNC, 32'h1FC}};
   logic clk_sys = 1'b0, srst = 1'b1, uc_issue_req = 1'b0, uc_done = 1'b0;
   logic older_all_done = 1'b1, disp_ready, uc_issue_ok;
   logic load_store_unit_op_valid;
   logic bus_req, bus_ack, pf_flush, sync_done;
   logic [3:0] lat = 4'h0;
   mosy_pkg::mosy_disp_t  disp_in = '0;
   mosy_pkg::mosy_op_t    load_store_unit_op;
   mosy_pkg::mosy_bus_t   bus_kind;
   mosy_pkg::mosy_fetch_t refetch;
   int n_mismatch = 0, checks = 0, i, k;
   mosy_ctrl uut (.*);
   mosy_bus_model bm (.*);
   always #4 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] g, e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic go(input int r);
      disp_in = '{1'b1, rows[r].op, rows[r].pc};
      @(negedge clk_sys);
      disp_in.valid = 1'b0;
   endtask
   task automatic wt;
      for (k = 0; k < 60 && sync_done !== 1'b1; k++) @(negedge clk_sys);
      chk(sync_done, 1'b1);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      close_out;
   end
   initial begin
      repeat (3) @(negedge clk_sys);
      srst = 1'b0;
      for (i = 0; i < 3; i++) begin
         go(i);
         wt;
         if (rows[i].op == mosy_pkg::MOSY_OP_ISYNC) begin
            chk(refetch.addr, (rows[i].pc + 32'h4) & 32'hFFFF_FFF8);
            chk({pf_flush, refetch.valid}, 2'h3);
         end
         @(negedge clk_sys);
         $display("row %0d done", i);
      end
      uc_issue_req = 1'b1;
      lat = 4'h5;
      @(negedge clk_sys);
      go(0);
      repeat (4) @(negedge clk_sys);
      chk({bus_req, uc_issue_ok, disp_ready}, 3'h0);
      uc_issue_req = 1'b0;
      uc_done = 1'b1;
      @(negedge clk_sys);
      uc_done = 1'b0;
      wt;
      @(negedge clk_sys);
      $display("held access done");
      older_all_done = 1'b0;
      go(2);
      repeat (3) @(negedge clk_sys);
      chk(pf_flush, 1'b0);
      older_all_done = 1'b1;
      wt;
      chk({pf_flush, refetch.valid}, 2'h3);
      @(negedge clk_sys);
      older_all_done = 1'b0;
      go(2);
      repeat (3) @(negedge clk_sys);
      srst = 1'b1;
      @(negedge clk_sys);
      srst = 1'b0;
      chk({disp_ready, uc_issue_ok, bus_req}, 3'h6);
      $display("reset test done");
      close_out;
   end
endmodule
